// [core/sso_pkg.sv]
// constants for the software strap override control block
// ==========================================================
// How it works
// - AN on: 00 gives 10M, 01 gives 100M
// - AN on: 10 half only, 11 all modes
// - override loads decoded bits into mode, advertisement
// - indicator bit one selects mode 1, default one
// - indicator bit zero: mode 2/3 from the control select bit
// - override copies indicator bit into phy control
// - software sets done, then reset sequence completes
// - done bit zero holds the internal reset sequence
package sso_pkg;
  // ========================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] BASIC_MODE_IDX = 8'h00;
  localparam logic [7:0] ADVERT_IDX = 8'h04;
  localparam logic [7:0] STRAP1_IDX = 8'h09;
  localparam logic [7:0] IND_CTRL_IDX = 8'h18;
  localparam logic [7:0] PHY_CTRL_IDX = 8'h19;
  localparam int IDX_W = 8;
  localparam int MIN_ADDR_W = 10;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ========================================================
  // strap override control 1 fields
  localparam int STRAP_DONE_BIT = 15;
  localparam int STRAP_NEG_EN_BIT = 13;
  localparam int STRAP_MODE_HI = 12;
  localparam int STRAP_MODE_LO = 11;
  localparam int STRAP_IND_BIT = 10;
  localparam logic [15:0] STRAP_RESET = 16'h3c00;
  localparam logic [15:0] STRAP_WMASK = 16'hbc00;

  // ========================================================
  // basic mode control and advertisement fields
  localparam int BM_SPEED_BIT = 13;
  localparam int BM_NEGOTIATION_ENABLE_BIT_BIT = 12;
  localparam int BM_DUPLEX_BIT = 8;
  localparam logic [15:0] BASIC_MODE_RESET = 16'h3100;
  localparam int ADV_10H_BIT = 5;
  localparam int ADV_10F_BIT = 6;
  localparam int ADV_100H_BIT = 7;
  localparam int ADV_100F_BIT = 8;
  localparam logic [15:0] ADVERT_SELECTOR = 16'h0001;
  localparam logic [15:0] ADVERT_RESET = 16'h01e1;

  // ========================================================
  // indicator and phy control fields
  localparam int PHY_IND_BIT = 5;
  localparam logic [15:0] PHY_CTRL_RESET = 16'h0020;
  localparam int IND_SEL_BIT = 5;
  localparam int IND_AUX_BIT = 6;
  localparam logic [15:0] IND_CTRL_RESET = 16'h0000;
  localparam logic [1:0] IND_MODE1 = 2'h1;
  localparam logic [1:0] IND_MODE2 = 2'h2;
  localparam logic [1:0] IND_MODE3 = 2'h3;

  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_LOAD,
    SEQ_RUN
  } sso_seq_t;
endpackage

// [core/sso_strap_decode.sv]
// decoder from strap override bits to register images
`timescale 1ns/1ps
module sso_strap_decode
  import sso_pkg::*;
(
  input wire logic negotiationEnable,
  input wire logic [1:0] negModeField,
  input wire logic indicatorConfig,
  input wire logic [15:0] basicModeNow,
  input wire logic [15:0] phyCtrlNow,
  output logic [15:0] basicModeImage,
  output logic [15:0] advertImage,
  output logic [15:0] phyCtrlImage
);
  always_comb begin
    advertImage = ADVERT_SELECTOR;
    case (negModeField)
      2'h0: begin
        advertImage[ADV_10H_BIT] = 1'b1;
        advertImage[ADV_10F_BIT] = 1'b1;
      end
      2'h1: begin
        advertImage[ADV_100H_BIT] = 1'b1;
        advertImage[ADV_100F_BIT] = 1'b1;
      end
      2'h2: begin
        advertImage[ADV_10H_BIT] = 1'b1;
        advertImage[ADV_100H_BIT] = 1'b1;
      end
      default: begin
        advertImage[ADV_10H_BIT] = 1'b1;
        advertImage[ADV_10F_BIT] = 1'b1;
        advertImage[ADV_100H_BIT] = 1'b1;
        advertImage[ADV_100F_BIT] = 1'b1;
      end
    endcase
    basicModeImage = basicModeNow;
    basicModeImage[BM_NEGOTIATION_ENABLE_BIT_BIT] = negotiationEnable;
    // forced mode: high code bit is speed, low code bit is duplex
    basicModeImage[BM_SPEED_BIT] = negotiationEnable | negModeField[1];
    basicModeImage[BM_DUPLEX_BIT] = negotiationEnable | negModeField[0];
    phyCtrlImage = phyCtrlNow;
    phyCtrlImage[PHY_IND_BIT] = indicatorConfig;
  end
endmodule

// [core/sso_strap_override_ctrl.sv]
// strap override register bank with ahb-lite slave and reset sequencer
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
module sso_strap_override_ctrl
  import sso_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic strapOverride,
  output logic resetSeqDone,
  output logic [15:0] basicModeCtrl,
  output logic [15:0] advertCtrl,
  output logic [15:0] phyCtrl,
  output logic [1:0] indicatorMode
);
  // ========================================================
  // parameter check
  generate
    if (ADDR_W < MIN_ADDR_W) begin : g_bad_addr
      $error("address width too small for the register map");
    end
  endgenerate

  // ========================================================
  // strap override pin synchroniser
  logic ovrMeta_ff;
  logic ovrSync_ff;
  logic nxt_ovrMeta;
  logic nxt_ovrSync;

  always_comb begin
    nxt_ovrMeta = strapOverride;
    nxt_ovrSync = ovrMeta_ff;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ovrMeta_ff <= 1'b0;
      ovrSync_ff <= 1'b0;
    end else begin
      ovrMeta_ff <= nxt_ovrMeta;
      ovrSync_ff <= nxt_ovrSync;
    end
  end

  // ========================================================
  // bus slave: zero-wait writes, one wait state on reads
  logic wrPend_ff;
  logic rdPend_ff;
  logic [IDX_W-1:0] idx_ff;
  logic [31:0] rdData_ff;
  logic nxt_wrPend;
  logic nxt_rdPend;
  logic [IDX_W-1:0] nxt_idx;
  logic [31:0] nxt_rdData;
  logic take;
  logic [15:0] rdMux;

  logic [15:0] strap_ff;
  logic [15:0] basic_ff;
  logic [15:0] advert_ff;
  logic [15:0] phy_ff;
  logic [15:0] indCtrl_ff;

  always_comb begin
    take = hsel & htrans[1] & hready;
    nxt_wrPend = take & hwrite & (hsize == HSIZE_WORD) & (haddr[1:0] == 2'h0);
    nxt_rdPend = take & ~hwrite;
    nxt_idx = take ? haddr[IDX_W+1:2] : idx_ff;
    case (idx_ff)
      BASIC_MODE_IDX: rdMux = basic_ff;
      ADVERT_IDX: rdMux = advert_ff;
      STRAP1_IDX: rdMux = strap_ff;
      IND_CTRL_IDX: rdMux = indCtrl_ff;
      PHY_CTRL_IDX: rdMux = phy_ff;
      default: rdMux = 16'h0000;
    endcase
    // read data is sampled in the wait cycle so a write just before lands first
    nxt_rdData = rdPend_ff ? {16'h0000, rdMux} : rdData_ff;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      idx_ff <= 8'h00;
      rdData_ff <= 32'h0000_0000;
    end else begin
      wrPend_ff <= nxt_wrPend;
      rdPend_ff <= nxt_rdPend;
      idx_ff <= nxt_idx;
      rdData_ff <= nxt_rdData;
    end
  end

  assign hreadyout = ~rdPend_ff;
  assign hresp = 1'b0;
  assign hrdata = rdData_ff;

  // ========================================================
  // reset sequencer
  sso_seq_t seq_ff;
  sso_seq_t nxt_seq;
  logic doneBit;

  assign doneBit = strap_ff[STRAP_DONE_BIT];

  always_comb begin
    nxt_seq = seq_ff;
    unique case (seq_ff)
      SEQ_HOLD: begin
        if (doneBit) begin
          nxt_seq = SEQ_LOAD;
        end
      end
      SEQ_LOAD: begin
        // done cleared while loading must not let the sequence run
        nxt_seq = doneBit ? SEQ_RUN : SEQ_HOLD;
      end
      SEQ_RUN: begin
        // clearing done again stalls the sequence until set anew
        if (!doneBit) begin
          nxt_seq = SEQ_HOLD;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seq_ff <= SEQ_HOLD;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  assign resetSeqDone = (seq_ff == SEQ_RUN);

  // ========================================================
  // register bank
  logic loadNow;
  logic [15:0] basicImg;
  logic [15:0] advertImg;
  logic [15:0] phyImg;
  logic [15:0] wrVal;
  logic [15:0] nxt_strap;
  logic [15:0] nxt_basic;
  logic [15:0] nxt_advert;
  logic [15:0] nxt_phy;
  logic [15:0] nxt_indCtrl;

  assign loadNow = (seq_ff == SEQ_LOAD) & ovrSync_ff;

  sso_strap_decode u_decode (
    .negotiationEnable(strap_ff[STRAP_NEG_EN_BIT]),
    .negModeField(strap_ff[STRAP_MODE_HI:STRAP_MODE_LO]),
    .indicatorConfig(strap_ff[STRAP_IND_BIT]),
    .basicModeNow(basic_ff),
    .phyCtrlNow(phy_ff),
    .basicModeImage(basicImg),
    .advertImage(advertImg),
    .phyCtrlImage(phyImg)
  );

  always_comb begin
    wrVal = hwdata[15:0];
    nxt_strap = strap_ff;
    nxt_basic = basic_ff;
    nxt_advert = advert_ff;
    nxt_phy = phy_ff;
    nxt_indCtrl = indCtrl_ff;
    if (wrPend_ff) begin
      case (idx_ff)
        BASIC_MODE_IDX: nxt_basic = wrVal;
        ADVERT_IDX: nxt_advert = wrVal;
        STRAP1_IDX: nxt_strap = wrVal & STRAP_WMASK;
        IND_CTRL_IDX: nxt_indCtrl = wrVal;
        PHY_CTRL_IDX: nxt_phy = wrVal;
        default: nxt_strap = strap_ff;
      endcase
    end
    // the strap load wins over a software write in the same cycle
    if (loadNow) begin
      nxt_basic = basicImg;
      nxt_advert = advertImg;
      nxt_phy = phyImg;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strap_ff <= STRAP_RESET;
      basic_ff <= BASIC_MODE_RESET;
      advert_ff <= ADVERT_RESET;
      phy_ff <= PHY_CTRL_RESET;
      indCtrl_ff <= IND_CTRL_RESET;
    end else begin
      strap_ff <= nxt_strap;
      basic_ff <= nxt_basic;
      advert_ff <= nxt_advert;
      phy_ff <= nxt_phy;
      indCtrl_ff <= nxt_indCtrl;
    end
  end

  assign basicModeCtrl = basic_ff;
  assign advertCtrl = advert_ff;
  assign phyCtrl = phy_ff;

  // ========================================================
  // indicator mode select; only the select bit picks 2 or 3
  always_comb begin
    if (phy_ff[PHY_IND_BIT]) begin
      indicatorMode = IND_MODE1;
    end else if (indCtrl_ff[IND_SEL_BIT]) begin
      indicatorMode = IND_MODE3;
    end else begin
      indicatorMode = IND_MODE2;
    end
  end

  // ========================================================
  // assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  logic [1:0] codeNow;
  logic negEnNow;
  assign codeNow = strap_ff[STRAP_MODE_HI:STRAP_MODE_LO];
  assign negEnNow = strap_ff[STRAP_NEG_EN_BIT];

  sequence s_loadCode(logic [1:0] c);
    loadNow && negEnNow && codeNow == c;
  endsequence

  property p_adv10only;
    s_loadCode(2'h0) |=> advert_ff[8:5] == 4'h3;
  endproperty
  a_adv10only: assert property (p_adv10only) else $error("code 00 advert wrong");

  property p_adv100only;
    s_loadCode(2'h1) |=> advert_ff[8:5] == 4'hc;
  endproperty
  a_adv100only: assert property (p_adv100only) else $error("code 01 advert wrong");

  property p_advHalf;
    s_loadCode(2'h2) |=> advert_ff[8:5] == 4'h5 && advert_ff[4:0] == 5'h01;
  endproperty
  a_advHalf: assert property (p_advHalf) else $error("code 10 advert wrong");

  property p_advAll;
    s_loadCode(2'h3) |=> advert_ff[8:5] == 4'hf;
  endproperty
  a_advAll: assert property (p_advAll) else $error("code 11 advert wrong");

  property p_forced;
    loadNow && !negEnNow && codeNow[1] |=>
      !basic_ff[12] && basic_ff[13] && basic_ff[8] == $past(codeNow[0]);
  endproperty
  a_forced: assert property (p_forced) else $error("forced 100 mode wrong");

  property p_loadBasic;
    loadNow |=> basic_ff[12] == $past(negEnNow) &&
      basic_ff[13] == ($past(negEnNow) | $past(codeNow[1]));
  endproperty
  a_loadBasic: assert property (p_loadBasic) else $error("enable not loaded");

  property p_mode1;
    phy_ff[5] |-> indicatorMode == 2'h1;
  endproperty
  a_mode1: assert property (p_mode1) else $error("indicator mode 1 wrong");

  property p_mode23;
    !phy_ff[5] |-> indicatorMode == (indCtrl_ff[5] ? 2'h3 : 2'h2);
  endproperty
  a_mode23: assert property (p_mode23) else $error("indicator mode 2/3 wrong");

  property p_ledCopy;
    loadNow |=> phy_ff[5] == $past(strap_ff[10]);
  endproperty
  a_ledCopy: assert property (p_ledCopy) else $error("indicator bit not copied");

  sequence s_doneRise;
    $rose(doneBit) && seq_ff == SEQ_HOLD;
  endsequence

  property p_doneRuns;
    s_doneRise |=> seq_ff == SEQ_LOAD ##1 (resetSeqDone || !$past(doneBit));
  endproperty
  a_doneRuns: assert property (p_doneRuns) else $error("sequence did not complete");

  property p_holdWhileClear;
    !doneBit |=> !resetSeqDone;
  endproperty
  a_holdWhileClear: assert property (p_holdWhileClear) else $error("ran without done");
endmodule

// [dv/sso_strap_override_ctrl_test.sv]
// self-checking testbench for the strap override register bank
`timescale 1ns/1ps
module sso_strap_override_ctrl_test;
  import sso_pkg::*;
  // ==========================================================
  // signals
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [9:0] haddr = 10'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic strapOverride = 1'b1;
  logic resetSeqDone;
  logic [15:0] basicModeCtrl;
  logic [15:0] advertCtrl;
  logic [15:0] phyCtrl;
  logic [1:0] indicatorMode;
  int miscompares = 0;
  int checkCount = 0;
  logic [31:0] rd;
  logic [15:0] expBasic;
  logic [15:0] expAdv;
  logic [15:0] sv;
  logic en;
  logic ind;
  logic [1:0] code;
  localparam logic [9:0] STRAP_A = {STRAP1_IDX, 2'b00};
  localparam logic [9:0] IND_A = {IND_CTRL_IDX, 2'b00};
  localparam logic [9:0] BASIC_A = {BASIC_MODE_IDX, 2'b00};
  localparam logic [9:0] HOLE_A = 10'h3fc;

  assign hready = hreadyout;
  always #5 clock = ~clock;

  sso_strap_override_ctrl #(.ADDR_W(10)) i_dut (
    .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .strapOverride(strapOverride), .resetSeqDone(resetSeqDone),
    .basicModeCtrl(basicModeCtrl), .advertCtrl(advertCtrl), .phyCtrl(phyCtrl),
    .indicatorMode(indicatorMode)
  );

  // ==========================================================
  // reporting
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ==========================================================
  // bus tasks: ready is looked at mid-cycle, which is what the next rising edge samples
  task automatic waitReady(output logic [31:0] data);
    bit ok;
    ok = 0;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(negedge clock);
      ok = (hreadyout === 1'b1);
      data = hrdata;
      @(posedge clock);
    end
    if (!ok) begin
      miscompares++;
      $display("mismatch hready expected 1 seen timeout");
      wrapUp();
    end
  endtask

  task automatic busWrite(input logic [9:0] a, input logic [15:0] d);
    logic [31:0] dummy;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    hsize <= HSIZE_WORD;
    waitReady(dummy);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    waitReady(dummy);
  endtask

  task automatic busRead(input logic [9:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    hsize <= HSIZE_WORD;
    waitReady(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    waitReady(d);
  endtask

  // sequence completion is a level, so it is polled under a bound
  task automatic waitDone();
    bit ok;
    ok = 0;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(negedge clock);
      ok = (resetSeqDone === 1'b1);
      @(posedge clock);
    end
    if (!ok) begin
      miscompares++;
      $display("mismatch resetSeqDone expected 1 seen timeout");
      wrapUp();
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    checkVal("basic reset", 32'h3100, basicModeCtrl);
    checkVal("advert reset", 32'h01e1, advertCtrl);
    checkVal("phy reset", 32'h0020, phyCtrl);
    checkVal("mode reset", IND_MODE1, indicatorMode);
    checkVal("done reset", 32'h0, resetSeqDone);
    checkVal("hresp", 32'h0, hresp);
    @(posedge clock);
    busRead(STRAP_A, rd);
    checkVal("strap reset", 32'h3c00, rd);
    busWrite(HOLE_A, 16'hffff);
    busRead(HOLE_A, rd);
    checkVal("unmapped", 32'h0, rd);
    busWrite(STRAP_A, 16'h7fff);
    busRead(STRAP_A, rd);
    checkVal("strap mask", 32'h3c00, rd);
    busWrite(STRAP_A | 10'h002, 16'hffff);
    busRead(STRAP_A, rd);
    checkVal("strap misaligned", 32'h3c00, rd);
    checkVal("done held", 32'h0, resetSeqDone);
    $display("test reset and access done");

    // every enable and mode code, loaded under override
    for (int i = 0; i < 8; i++) begin
      en = i[2];
      code = i[1:0];
      ind = i[2] ^ i[0];
      sv = {2'b00, en, code, ind, 10'h000};
      busWrite(STRAP_A, sv);
      repeat (2) @(posedge clock);
      @(negedge clock);
      checkVal("done cleared", 32'h0, resetSeqDone);
      @(posedge clock);
      busWrite(STRAP_A, sv | 16'h8000);
      waitDone();
      expBasic = 16'h0000;
      expBasic[BM_SPEED_BIT] = en | code[1];
      expBasic[BM_NEGOTIATION_ENABLE_BIT_BIT] = en;
      expBasic[BM_DUPLEX_BIT] = en | code[0];
      expAdv = ADVERT_SELECTOR;
      expAdv[ADV_10H_BIT] = (code != 2'h1);
      expAdv[ADV_10F_BIT] = (code == 2'h0) || (code == 2'h3);
      expAdv[ADV_100H_BIT] = (code != 2'h0);
      expAdv[ADV_100F_BIT] = (code == 2'h1) || (code == 2'h3);
      @(negedge clock);
      checkVal("basic load", expBasic, basicModeCtrl);
      checkVal("advert load", expAdv, advertCtrl);
      checkVal("phy load", {26'h0, ind, 5'h00}, phyCtrl);
      checkVal("indicator mode", ind ? IND_MODE1 : IND_MODE2, indicatorMode);
      @(posedge clock);
      busRead(BASIC_A, rd);
      checkVal("basic read", expBasic, rd);
    end
    $display("test strap decode done");

    busWrite(IND_A, 16'h0060);
    busRead(IND_A, rd);
    checkVal("indicator ctrl", 32'h0060, rd);
    checkVal("indicator mode3", IND_MODE3, indicatorMode);
    busWrite(IND_A, 16'h0040);
    @(negedge clock);
    checkVal("indicator mode2", IND_MODE2, indicatorMode);
    @(posedge clock);
    $display("test indicator done");

    // without override the registers keep the last loaded images
    strapOverride <= 1'b0;
    busWrite(STRAP_A, 16'h2400);
    repeat (4) @(posedge clock);
    busWrite(STRAP_A, 16'ha400);
    waitDone();
    @(negedge clock);
    checkVal("basic kept", 32'h3100, basicModeCtrl);
    checkVal("advert kept", 32'h01e1, advertCtrl);
    checkVal("phy kept", 32'h0000, phyCtrl);
    $display("test no override done");
    wrapUp();
  end
endmodule
